/* logic/ipr_pkg.sv */
// package: constants, types and helpers of the interrupt priority resolver
package ipr_pkg;
  localparam int NSRC = 16;
  localparam int IDX_W = 4;
  localparam int LVL_W = 3;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_ICR0 = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_PSL = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_PSH = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h13;
  localparam int ICR_REQ_BIT = 3;
  localparam int MODE_DET_LSB = 4;
  localparam int PS_I_BIT = 2;
  localparam int PS_IPL_LSB = 8;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] PS_RESET = 16'h0004;
  localparam logic [1:0] DET_SEL_7 = 2'h0;
  localparam logic [1:0] DET_SEL_4 = 2'h1;
  localparam logic [1:0] DET_SEL_2 = 2'h2;
  localparam logic [2:0] DET_LEN_7 = 3'h7;
  localparam logic [2:0] DET_LEN_4 = 3'h4;
  localparam logic [2:0] DET_LEN_2 = 3'h2;
  localparam int ACK_CYCLES = 13;
  localparam int STACK_BYTES = 5;
  localparam logic [2:0] IPL_WDT = 3'h7;
  localparam logic [7:0] BANK_VECTOR = 8'h00;
  localparam logic [15:0] VEC_ZDIV = 16'hFFFC;
  localparam logic [15:0] VEC_BRK = 16'hFFFA;
  localparam logic [15:0] VEC_WDT = 16'hFFF8;
  localparam logic [15:0] VEC_SRC_TOP = 16'hFFD6;

  typedef logic [LVL_W-1:0] ipr_lvl_t;
  typedef enum logic [1:0] {KIND_SRC, KIND_WDT, KIND_ZDIV, KIND_BRK} ipr_kind_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACK, SEQ_RTI} ipr_seq_t;

  function automatic logic levelAbove(input ipr_lvl_t a, input ipr_lvl_t b);
    return a > b;
  endfunction

  function automatic logic [2:0] detLen(input logic [1:0] sel);
    case (sel)
      DET_SEL_4: return DET_LEN_4;
      DET_SEL_2: return DET_LEN_2;
      default: return DET_LEN_7;
    endcase
  endfunction

  function automatic logic [15:0] srcVector(input logic [IDX_W-1:0] idx);
    return VEC_SRC_TOP - {11'h000, idx, 1'b0};
  endfunction
endpackage

/* logic/ipr_chain_if.sv */
// interface: latched requests into the comparator chain, winner out of it
`timescale 1ns/1ps
interface ipr_chain_if import ipr_pkg::*; ();
  logic [NSRC-1:0] req;
  logic [NSRC-1:0][LVL_W-1:0] lvl;
  logic winValid;
  logic [IDX_W-1:0] winIdx;
  ipr_lvl_t winLvl;
  modport resolver (output req, output lvl, input winValid, input winIdx, input winLvl);
  modport chain (input req, input lvl, output winValid, output winIdx, output winLvl);
endinterface

/* logic/ipr_chain.sv */
// module: daisy-chained level comparator over the latched sources
`timescale 1ns/1ps
module ipr_chain import ipr_pkg::*; (
  ipr_chain_if.chain ch
);
  always_comb begin
    ipr_lvl_t run;
    logic [IDX_W-1:0] idx;
    logic hit;
    run = '0;
    idx = '0;
    hit = 1'b0;
    // stage i forwards the running winner unless its source is requested and higher
    for (int i = 0; i < NSRC; i++) begin
      if (ch.req[i] && levelAbove(ch.lvl[i], run)) begin
        run = ch.lvl[i];
        idx = IDX_W'(i);
        hit = 1'b1;
      end
    end
    ch.winValid = hit;
    ch.winIdx = idx;
    ch.winLvl = run;
  end
endmodule

/* logic/ipr_resolver.sv */
// module: interrupt priority resolver with acknowledge and return sequencing
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - chain carries running winner, starting at zero
// - unrequested source passes running winner unchanged
// - equal levels: earlier chain entry wins
// - accept only above priority level, disable clear
// - sample on fetch pulse, hold until done
// - no new sampling while check runs
// - mode bits 4,5 pick 2/4/7 cycles
// - reset clears selection to seven cycles
// - acknowledge only after current instruction ends
// - push bank, pc high, pc low, status
// - set disable, clear request, load level
// - bank to zero, pc from vector
// - level update per source kind on entry
// - rejected and other requests stay pending
// - acknowledge lasts at least thirteen cycles
// - detect at instruction start and acknowledge
// - return pops bank, pc and status
// - request flag at control bit three
// - level in bits 0-2, zero never accepted
// - priority level in status bits 8-10
module ipr_resolver import ipr_pkg::*; #(
  parameter int ACK_LEN = ACK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [NSRC-1:0] srcEvent,
  input wire logic wdtEvent,
  input wire logic zdivEvent,
  input wire logic brkEvent,
  input wire logic opFetch,
  input wire logic instrDone,
  input wire logic rtiReq,
  input wire logic [7:0] curBank,
  input wire logic [15:0] curPc,
  input wire logic [7:0] popData,
  output logic pushReq,
  output logic [7:0] pushData,
  output logic popReq,
  output logic pcLoad,
  output logic pcIsVector,
  output logic [15:0] pcValue,
  output logic [7:0] bankValue,
  output logic [15:0] psOut
);
  if (ACK_LEN < ACK_CYCLES || ACK_LEN > 31) begin : g_chk
    $error("ACK_LEN must lie between 13 and 31");
  end

  typedef struct packed {
    logic [NSRC-1:0] req;
    logic [NSRC-1:0][LVL_W-1:0] lvl;
    logic [7:0] mode;
    logic [15:0] ps;
    logic [NSRC-1:0] snapReq;
    logic [NSRC-1:0][LVL_W-1:0] snapLvl;
    logic detBusy;
    logic [2:0] detCnt;
    logic winAccept;
    logic [IDX_W-1:0] winIdx;
    ipr_lvl_t winLvl;
    logic nmiWdt;
    logic nmiZdiv;
    logic nmiBrk;
    ipr_seq_t seq;
    logic [4:0] seqCnt;
    ipr_kind_t kind;
    logic [IDX_W-1:0] ackIdx;
    ipr_lvl_t ackLvl;
    logic pushReq;
    logic [7:0] pushData;
    logic popReq;
    logic pcLoad;
    logic pcIsVector;
    logic [15:0] pcValue;
    logic [7:0] bankValue;
    logic [7:0] rdData;
  } ipr_state_t;

  ipr_state_t st_r;
  ipr_state_t st_nxt;
  logic ackGo;
  logic detStart;
  logic srcOk;
  ipr_lvl_t processor_priority_level;
  logic iFlag;
  logic [IDX_W-1:0] regIdx;

  ipr_chain_if ch ();

  ipr_chain u_chain (
    .ch(ch)
  );

  assign ch.req = st_r.snapReq;
  assign ch.lvl = st_r.snapLvl;
  assign processor_priority_level = st_r.ps[PS_IPL_LSB +: LVL_W];
  assign iFlag = st_r.ps[PS_I_BIT];
  assign regIdx = regAddr[IDX_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.pushReq = 1'b0;
    st_nxt.popReq = 1'b0;
    st_nxt.pcLoad = 1'b0;
    st_nxt.rdData = 8'h00;
    ackGo = 1'b0;
    // events are sticky and independent of all masking
    st_nxt.req = st_r.req | srcEvent;
    st_nxt.nmiWdt = st_r.nmiWdt | wdtEvent;
    st_nxt.nmiZdiv = st_r.nmiZdiv | zdivEvent;
    st_nxt.nmiBrk = st_r.nmiBrk | brkEvent;

    // register port
    if (regWr) begin
      if (regAddr[ADDR_W-1] == ADDR_ICR0[ADDR_W-1]) begin
        st_nxt.lvl[regIdx] = regWrData[LVL_W-1:0];
        st_nxt.req[regIdx] = regWrData[ICR_REQ_BIT] | srcEvent[regIdx];
      end else begin
        case (regAddr)
          ADDR_MODE: st_nxt.mode = regWrData;
          ADDR_PSL: st_nxt.ps[7:0] = regWrData;
          ADDR_PSH: st_nxt.ps[15:8] = regWrData;
          default: ;
        endcase
      end
    end
    if (regRd) begin
      if (regAddr[ADDR_W-1] == ADDR_ICR0[ADDR_W-1]) begin
        st_nxt.rdData = {4'h0, st_r.req[regIdx], st_r.lvl[regIdx]};
      end else begin
        case (regAddr)
          ADDR_MODE: st_nxt.rdData = st_r.mode;
          ADDR_PSL: st_nxt.rdData = st_r.ps[7:0];
          ADDR_PSH: st_nxt.rdData = st_r.ps[15:8];
          ADDR_STAT: st_nxt.rdData = {st_r.winAccept, st_r.seq != SEQ_IDLE, st_r.detBusy,
                                      1'b0, st_r.winIdx};
          default: st_nxt.rdData = 8'h00;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // acceptance is rechecked against the live status at the instruction boundary
    srcOk = st_r.winAccept && st_r.req[st_r.winIdx] && levelAbove(st_r.winLvl, processor_priority_level)
            && !iFlag;
    case (st_r.seq)
      SEQ_IDLE: begin
        if (instrDone && (st_r.nmiWdt || st_r.nmiZdiv || st_r.nmiBrk || srcOk)) begin
          ackGo = 1'b1;
          st_nxt.seq = SEQ_ACK;
          st_nxt.seqCnt = 5'h00;
          if (st_r.nmiWdt) begin
            st_nxt.kind = KIND_WDT;
            st_nxt.nmiWdt = wdtEvent;
          end else if (st_r.nmiZdiv) begin
            st_nxt.kind = KIND_ZDIV;
            st_nxt.nmiZdiv = zdivEvent;
          end else if (st_r.nmiBrk) begin
            st_nxt.kind = KIND_BRK;
            st_nxt.nmiBrk = brkEvent;
          end else begin
            st_nxt.kind = KIND_SRC;
            st_nxt.ackIdx = st_r.winIdx;
            st_nxt.ackLvl = st_r.winLvl;
            st_nxt.winAccept = 1'b0;
          end
        end else if (rtiReq) begin
          st_nxt.seq = SEQ_RTI;
          st_nxt.seqCnt = 5'h00;
        end
      end
      SEQ_ACK: begin
        st_nxt.seqCnt = st_r.seqCnt + 5'h01;
        if (st_r.seqCnt < 5'(STACK_BYTES)) begin
          st_nxt.pushReq = 1'b1;
          case (st_r.seqCnt)
            5'h00: st_nxt.pushData = curBank;
            5'h01: st_nxt.pushData = curPc[15:8];
            5'h02: st_nxt.pushData = curPc[7:0];
            5'h03: st_nxt.pushData = st_r.ps[15:8];
            default: st_nxt.pushData = st_r.ps[7:0];
          endcase
        end
        // status is already on the stack, so it can be updated now
        if (st_r.seqCnt == 5'(STACK_BYTES)) begin
          st_nxt.ps[PS_I_BIT] = 1'b1;
          case (st_r.kind)
            KIND_SRC: begin
              // only the accepted source is cleared, the rest stay pending
              st_nxt.req[st_r.ackIdx] = srcEvent[st_r.ackIdx];
              st_nxt.ps[PS_IPL_LSB +: LVL_W] = st_r.ackLvl;
            end
            KIND_WDT: st_nxt.ps[PS_IPL_LSB +: LVL_W] = IPL_WDT;
            default: ;
          endcase
        end
        if (st_r.seqCnt == 5'(ACK_LEN - 1)) begin
          st_nxt.pcLoad = 1'b1;
          st_nxt.pcIsVector = 1'b1;
          st_nxt.bankValue = BANK_VECTOR;
          case (st_r.kind)
            KIND_WDT: st_nxt.pcValue = VEC_WDT;
            KIND_ZDIV: st_nxt.pcValue = VEC_ZDIV;
            KIND_BRK: st_nxt.pcValue = VEC_BRK;
            default: st_nxt.pcValue = srcVector(st_r.ackIdx);
          endcase
          st_nxt.seq = SEQ_IDLE;
        end
      end
      SEQ_RTI: begin
        // pops come back in the same cycle as each request, in reverse push order
        // one pop per saved byte, so the stack is balanced again after return
        st_nxt.seqCnt = st_r.seqCnt + 5'h01;
        st_nxt.popReq = st_r.seqCnt < 5'(STACK_BYTES);
        case (st_r.seqCnt)
          5'h01: st_nxt.ps[7:0] = popData;
          5'h02: st_nxt.ps[15:8] = popData;
          5'h03: st_nxt.pcValue[7:0] = popData;
          5'h04: st_nxt.pcValue[15:8] = popData;
          5'h05: begin
            st_nxt.bankValue = popData;
            st_nxt.pcLoad = 1'b1;
            st_nxt.pcIsVector = 1'b0;
            st_nxt.seq = SEQ_IDLE;
          end
          default: ;
        endcase
      end
      default: st_nxt.seq = SEQ_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////////////
    // detection starts at fetch or acknowledge; an active check is never restarted
    detStart = !st_r.detBusy && (opFetch || ackGo);
    if (detStart) begin
      st_nxt.snapReq = st_r.req;
      st_nxt.snapLvl = st_r.lvl;
      st_nxt.detBusy = 1'b1;
      st_nxt.detCnt = detLen(st_r.mode[MODE_DET_LSB +: 2]) - 3'h1;
    end else if (st_r.detBusy) begin
      if (st_r.detCnt == 3'h0) begin
        st_nxt.detBusy = 1'b0;
        st_nxt.winIdx = ch.winIdx;
        st_nxt.winLvl = ch.winLvl;
        st_nxt.winAccept = ch.winValid && levelAbove(ch.winLvl, processor_priority_level) && !iFlag;
      end else begin
        st_nxt.detCnt = st_r.detCnt - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.mode <= MODE_RESET;
      st_r.ps <= PS_RESET;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign pushReq = st_r.pushReq;
  assign pushData = st_r.pushData;
  assign popReq = st_r.popReq;
  assign pcLoad = st_r.pcLoad;
  assign pcIsVector = st_r.pcIsVector;
  assign pcValue = st_r.pcValue;
  assign bankValue = st_r.bankValue;
  assign psOut = st_r.ps;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence sDetStart2;
    clkEn && detStart && detLen(st_r.mode[MODE_DET_LSB +: 2]) == DET_LEN_2;
  endsequence

  sequence sAckStart;
    clkEn && ackGo;
  endsequence

  AST_CHAIN_MAX: assert property (ch.req[1] |-> !levelAbove(ch.lvl[1], ch.winLvl))
    else $error("a requested source outranks the winner");
  AST_NO_UNREQ: assert property (ch.winValid |-> ch.req[ch.winIdx])
    else $error("winner is not a requested source");
  AST_TIE_FIRST: assert property (ch.req[0] && ch.lvl[0] != 3'h0
    && ch.lvl[0] == ch.winLvl |-> ch.winIdx == 4'h0)
    else $error("equal level did not go to the earlier source");
  AST_SNAP_HOLD: assert property (st_r.detBusy && $past(st_r.detBusy)
    |-> $stable(st_r.snapReq) && $stable(st_r.snapLvl))
    else $error("latched requests changed during a check");
  AST_NO_RESAMPLE: assert property (st_r.detBusy && st_r.detCnt != 3'h0 && opFetch
    && clkEn |=> st_r.detCnt == $past(st_r.detCnt) - 3'h1)
    else $error("check restarted while busy");
  AST_DET_TWO: assert property (sDetStart2 ##1 clkEn [*2]
    |-> st_r.detBusy ##1 !st_r.detBusy)
    else $error("two-cycle detection has wrong length");
  AST_RESET_VAL: assert property ($fell(rst)
    |-> st_r.mode[MODE_DET_LSB +: 2] == DET_SEL_7 && st_r.ps == PS_RESET)
    else $error("wrong state after reset");
  AST_ACK_AFTER_INSTR: assert property ($rose(st_r.seq == SEQ_ACK) |-> $past(instrDone))
    else $error("acknowledge began inside an instruction");
  AST_PUSH_BANK: assert property (sAckStart ##1 clkEn
    |=> st_r.pushReq && st_r.pushData == $past(curBank))
    else $error("first push is not the program bank");
  AST_ACK_FLAGS: assert property (clkEn && st_r.seq == SEQ_ACK
    && st_r.kind == KIND_SRC && st_r.seqCnt == 5'(STACK_BYTES) && !regWr
    |=> st_r.ps[PS_I_BIT] && processor_priority_level == $past(st_r.ackLvl))
    else $error("flags not updated on acknowledge");
  AST_ACK_LEN: assert property (st_r.pcLoad && st_r.pcIsVector
    |-> $past(st_r.seqCnt) == 5'(ACK_LEN - 1) && st_r.bankValue == BANK_VECTOR)
    else $error("acknowledge too short");
  AST_SET_WINS: assert property (clkEn && srcEvent != '0
    |=> (st_r.req & $past(srcEvent)) == $past(srcEvent))
    else $error("request event lost");
endmodule

/* verif/ipr_stack_model.sv */
// stack memory model standing on the core side of the resolver
`timescale 1ns/1ps
module ipr_stack_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pushReq,
  input wire logic [7:0] pushData,
  input wire logic popReq,
  output logic [7:0] popData,
  output logic [7:0] depth
);
  logic [7:0] mem [256];
  // top byte is offered until its pop is seen at an edge; empty stack shows garbage
  assign popData = (depth == 8'h00) ? ~mem[0] : mem[depth - 8'h01];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      depth <= 8'h00;
    end else if (pushReq) begin
      mem[depth] <= pushData;
      depth <= depth + 8'h01;
    end else if (popReq) begin
      depth <= depth - 8'h01;
    end
  end
endmodule

/* verif/interrupt_priority_resolver_bench.sv */
// self-checking bench for the interrupt priority resolver
`timescale 1ns/1ps
module interrupt_priority_resolver_bench import ipr_pkg::*;;
  logic ref_clk, rst, regWr, regRd, opFetch, instrDone, rtiReq, wdtEvent, zdivEvent, brkEvent;
  logic pushReq, popReq, pcLoad, pcIsVector, acc;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWrData, regRdData, curBank, popData, bankValue, pushData, depth, rd;
  logic [15:0] srcEvent, curPc, pcValue, psOut, psExp, rq;
  logic [2:0] lv [NSRC];
  logic [2:0] processor_priority_level;
  logic [1:0] sel;
  int bad_count, compares, w, n, j, busyCnt, len;

  ipr_resolver #(.ACK_LEN(ACK_CYCLES)) i_ipr_resolver (
    .ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcEvent(srcEvent),
    .wdtEvent(wdtEvent), .zdivEvent(zdivEvent), .brkEvent(brkEvent), .opFetch(opFetch),
    .instrDone(instrDone), .rtiReq(rtiReq), .curBank(curBank), .curPc(curPc),
    .popData(popData), .pushReq(pushReq), .pushData(pushData), .popReq(popReq),
    .pcLoad(pcLoad), .pcIsVector(pcIsVector), .pcValue(pcValue), .bankValue(bankValue),
    .psOut(psOut));
  ipr_stack_model i_ipr_stack_model (
    .ref_clk(ref_clk), .rst(rst), .pushReq(pushReq), .pushData(pushData),
    .popReq(popReq), .popData(popData), .depth(depth));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rdreg(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask

  // bounded wait for the pc load pulse; n counts edges since the request
  task automatic waitLoad();
    n = 0;
    do begin
      @(posedge ref_clk);
      instrDone <= 1'b0;
      rtiReq <= 1'b0;
      #1 n++;
    end while (pcLoad !== 1'b1 && n < 60);
    if (pcLoad !== 1'b1) begin
      bad_count++;
      $display("unexpected pcLoad: expected 1, seen 0");
      finish_test();
    end
  endtask

  // acknowledge at instruction end, then return, checking stack and status
  task automatic service(input logic [15:0] vec, input logic [2:0] lvl, input int clr);
    logic [7:0] b;
    logic [15:0] p;
    logic [7:0] sb [5];
    logic [7:0] d0;
    b = 8'($urandom);
    p = 16'($urandom);
    d0 = depth;
    @(posedge ref_clk);
    curBank <= b;
    curPc <= p;
    instrDone <= 1'b1;
    psExp = psOut;
    sb = '{b, p[15:8], p[7:0], psExp[15:8], psExp[7:0]};
    waitLoad();
    check("ack length", 16'(ACK_CYCLES + 1), 16'(n));
    check("vector flag", 16'h0001, {15'h0000, pcIsVector});
    check("vector", vec, pcValue);
    check("bank", 16'h0000, {8'h00, bankValue});
    check("disable flag", 16'h0001, {15'h0000, psOut[PS_I_BIT]});
    check("level", {13'h0000, lvl}, {13'h0000, psOut[10:8]});
    for (int k = 0; k < 5; k++) begin
      check("stack", {8'h00, sb[k]}, {8'h00, i_ipr_stack_model.mem[depth - 8'(5 - k)]});
    end
    // the service routine clears the request of a late source before it returns
    if (clr >= 0) begin
      wr(ADDR_ICR0 + 5'(clr), {5'h00, lv[clr]});
    end
    @(posedge ref_clk);
    rtiReq <= 1'b1;
    waitLoad();
    check("return flag", 16'h0000, {15'h0000, pcIsVector});
    check("return pc", p, pcValue);
    check("return bank", {8'h00, b}, {8'h00, bankValue});
    check("return status", psExp, psOut);
    check("stack depth", {8'h00, d0}, {8'h00, depth});
    repeat (2) @(posedge ref_clk);
  endtask

  function automatic int winner();
    int b;
    b = -1;
    for (int i = 0; i < NSRC; i++) begin
      if (rq[i] === 1'b1 && lv[i] > ((b < 0) ? 3'h0 : lv[b])) begin
        b = i;
      end
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    {rst, regWr, regRd, opFetch, instrDone, rtiReq, wdtEvent, zdivEvent, brkEvent} = 9'h100;
    regAddr = '0;
    regWrData = 8'h00;
    srcEvent = 16'h0000;
    curBank = 8'h00;
    curPc = 16'h0000;
    bad_count = 0;
    compares = 0;
    w = $urandom(26);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdreg(ADDR_MODE);
    check("mode", 16'h0000, {8'h00, rd});
    check("status", PS_RESET, psOut);
    rdreg(5'h1F);
    check("unmapped", 16'h0000, {8'h00, rd});
    for (int t = 0; t < 12; t++) begin
      for (int i = 0; i < NSRC; i++) begin
        lv[i] = (t == 0) ? 3'h5 : 3'($urandom);
        rq[i] = (t == 0) || ((t != 3) && 1'($urandom));
        wr(ADDR_ICR0 + 5'(i), {4'($urandom), rq[i], lv[i]});
      end
      sel = 2'(t);
      processor_priority_level = (t == 1) ? 3'h7 : 3'($urandom);
      wr(ADDR_MODE, {2'h0, sel, 4'h0});
      wr(ADDR_PSH, {5'h00, processor_priority_level});
      wr(ADDR_PSL, {5'h00, t == 2, 2'h0});
      j = $urandom_range(15);
      @(posedge ref_clk);
      opFetch <= 1'b1;
      regRd <= 1'b1;
      regAddr <= ADDR_STAT;
      busyCnt = 0;
      // a second fetch pulse and a new event land while the check is busy
      for (int k = 0; k < 12; k++) begin
        @(posedge ref_clk);
        opFetch <= (k == 1);
        srcEvent <= (k == 1) ? 16'(1 << j) : 16'h0000;
        #1 if (regRdData[5] === 1'b1) busyCnt++;
      end
      rd = regRdData;
      @(posedge ref_clk);
      regRd <= 1'b0;
      len = (sel == 2'h1) ? 4 : ((sel == 2'h2) ? 2 : 7);
      check("busy cycles", 16'(len), 16'(busyCnt));
      w = winner();
      acc = (w >= 0) && (lv[w] > processor_priority_level) && (t != 2);
      check("accepted", {15'h0000, acc}, {15'h0000, rd[7]});
      if (w >= 0) begin
        check("winner", 16'(w), {12'h000, rd[3:0]});
      end
      rq[j] = 1'b1;
      if (acc) begin
        service(VEC_SRC_TOP - 16'(2 * w), lv[w], (j != w && t % 2 == 1) ? j : -1);
        rq[w] = 1'b0;
        if (j != w && t % 2 == 1) begin
          rq[j] = 1'b0;
        end
      end
      for (int i = 0; i < NSRC; i++) begin
        rdreg(ADDR_ICR0 + 5'(i));
        check("control", {12'h000, rq[i], lv[i]}, {8'h00, rd});
      end
    end
    wr(ADDR_PSH, 8'h03);
    wr(ADDR_PSL, 8'h04);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      wdtEvent <= (k == 0);
      zdivEvent <= (k == 1);
      brkEvent <= (k == 2);
      @(posedge ref_clk);
      {wdtEvent, zdivEvent, brkEvent} <= 3'h0;
      service((k == 0) ? VEC_WDT : ((k == 1) ? VEC_ZDIV : VEC_BRK),
              (k == 0) ? 3'h7 : 3'h3, -1);
    end
    finish_test();
  end
endmodule
